// ==== hw/nsal_apb_slave.sv ====
// apb slave front end: decodes one transfer, answers in the access phase
// assumes the master keeps a request stable until pready
`timescale 1ns/1ns
`default_nettype none
module nsal_apb_slave
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   output logic             wr_stb_out,
   output logic             rd_stb_out,
   output logic             pready_out
);
   // ***************
   // single access with one wait state
   // ***************
   // pready pulses one cycle into the access phase, so every transfer
   // takes exactly setup plus two access cycles
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pready_out <= 1'b0;
      end
      else
      begin
         pready_out <= psel_in & penable_in & ~pready_out;
      end
   end
   always_comb
   begin
      wr_stb_out = psel_in & penable_in & pready_out & pwrite_in;
      rd_stb_out = psel_in & penable_in & ~pready_out & ~pwrite_in;
   end
endmodule // nsal_apb_slave
`default_nettype wire

// ==== hw/nsal_lock_bank.sv ====
// region lock bits, changed only by lock and unlock commands, erase and reset
// assumes commands come from the command engine on the same clock
`timescale 1ns/1ns
`default_nettype none
module nsal_lock_bank
   import nsal_pkg::*;
#(
   parameter int REGIONS_P = 16
)
(
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  erase_in,
   input  wire logic                  cmd_stb_in,
   input  wire nsal_pkg::nsal_cmd_type cmd_in,
   input  wire logic [3:0]            region_in,
   output logic [REGIONS_P-1:0]       lock_out
);
   // ***************
   // lock state
   // ***************
   // a 0 means locked; an erased lock area reads all ones (unlocked)
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in | erase_in)
      begin
         lock_out <= REGIONS_P'(LOCK_ERASED);
      end
      else if (cmd_stb_in && cmd_in == NSAL_CMD_LOCK)
      begin
         lock_out[region_in] <= 1'b0;
      end
      else if (cmd_stb_in && cmd_in == NSAL_CMD_UNLOCK)
      begin
         lock_out[region_in] <= 1'b1;
      end
   end
endmodule // nsal_lock_bank
`default_nettype wire

// ==== hw/nsal_top.sv ====
// flash controller tail: status flags, command address and region locks
// assumes the command engine, page buffer and sleep logic share clk_in
`timescale 1ns/1ns
`default_nettype none
module nsal_top
   import nsal_pkg::*;
#(
   parameter int REGIONS_P = 16
)
(
   input  wire logic                   clk_in,
   input  wire logic                   sys_rst_in,
   input  wire logic                   psel_in,
   input  wire logic                   penable_in,
   input  wire logic                   pwrite_in,
   input  wire logic [7:0]             paddr_in,
   input  wire logic [31:0]            pwdata_in,
   output logic [31:0]                 prdata_out,
   output logic                        pready_out,
   output logic                        pslverr_out,
   input  wire logic                   pb_load_in,
   input  wire logic [21:0]            pb_addr_in,
   input  wire logic                   cmd_exec_in,
   input  wire nsal_pkg::nsal_cmd_type cmd_in,
   input  wire logic                   flash_access_in,
   input  wire logic                   sleep_enter_in,
   input  wire logic                   sleep_exit_in,
   input  wire logic                   sleep_power_reduction_select_in,
   input  wire logic                   lock_erase_in,
   input  wire logic                   busy_in,
   input  wire logic                   flash_error_in,
   input  wire logic                   locked_region_error_in,
   input  wire logic                   bad_command_error_in,
   output logic [15:0]                 flash_addr_out,
   output logic                        flash_cmd_stb_out,
   output logic                        power_reduction_out
);
   import nsal_pkg::*;

   logic                 wr_stb;
   logic                 rd_stb;
   logic                 pready_i;
   logic [21:0]          command_address;
   logic [REGIONS_P-1:0] region_lock_state;
   logic                 page_buffer_loaded;
   logic                 power_reduction_flag;
   logic                 flash_error_bit;
   logic                 locked_region_error_bit;
   logic                 bad_command_error_bit;
   logic                 error_flag;
   logic                 ready_flag;
   logic                 hit_status;
   logic                 hit_addr;
   logic                 hit_flag;
   logic                 hit_lock;
   logic [31:0]          next_prdata;
   logic                 cmd_write_page;
   logic                 cmd_pb_clear;

   // ***************
   // bus front end
   // ***************
   nsal_apb_slave u_apb
   (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .psel_in    (psel_in),
      .penable_in (penable_in),
      .pwrite_in  (pwrite_in),
      .wr_stb_out (wr_stb),
      .rd_stb_out (rd_stb),
      .pready_out (pready_i)
   );

   always_comb
   begin
      pready_out = pready_i;
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // write-one-to-clear strobe for one bit of one register
   function automatic logic w1c(input logic stb, input logic hit_reg,
                                input logic data_bit);
      w1c = stb & hit_reg & data_bit;
   endfunction

   always_comb
   begin
      hit_status = hit(paddr_in, ADDR_STATUS);
      hit_addr   = hit(paddr_in, ADDR_CMD_ADDR);
      hit_flag   = hit(paddr_in, ADDR_INTFLAG);
      hit_lock   = hit(paddr_in, ADDR_LOCK);
      cmd_write_page = cmd_exec_in && cmd_in == NSAL_CMD_WRITE_PAGE;
      cmd_pb_clear   = cmd_exec_in && cmd_in == NSAL_CMD_PB_CLEAR;
   end

   // ***************
   // page buffer loaded flag
   // ***************
   // a new load in the same cycle as a clear keeps the flag set
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         page_buffer_loaded <= 1'b0;
      end
      else if (pb_load_in)
      begin
         page_buffer_loaded <= 1'b1;
      end
      else if (cmd_write_page | cmd_pb_clear)
      begin
         page_buffer_loaded <= 1'b0;
      end
      else if (w1c(wr_stb, hit_status, pwdata_in[BIT_LOAD]))
      begin
         page_buffer_loaded <= 1'b0;
      end
   end

   // ***************
   // power reduction state
   // ***************
   // leaving wins over entering: a bus access must find the array awake
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         power_reduction_flag <= 1'b0;
      end
      else if (flash_access_in
               || (cmd_exec_in && cmd_in == NSAL_CMD_CLR_PWR_RED)
               || (sleep_exit_in && sleep_power_reduction_select_in))
      begin
         power_reduction_flag <= 1'b0;
      end
      else if ((cmd_exec_in && cmd_in == NSAL_CMD_SET_PWR_RED)
               || (sleep_enter_in && sleep_power_reduction_select_in))
      begin
         power_reduction_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         power_reduction_out <= 1'b0;
      end
      else
      begin
         power_reduction_out <= power_reduction_flag;
      end
   end

   // ***************
   // error bits, set over clear
   // ***************
   // an error in the same cycle as its clear must not be lost
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         flash_error_bit <= 1'b0;
      end
      else if (flash_error_in)
      begin
         flash_error_bit <= 1'b1;
      end
      else if (w1c(wr_stb, hit_status, pwdata_in[BIT_FLASH_ERR]))
      begin
         flash_error_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         locked_region_error_bit <= 1'b0;
      end
      else if (locked_region_error_in)
      begin
         locked_region_error_bit <= 1'b1;
      end
      else if (w1c(wr_stb, hit_status, pwdata_in[BIT_LOCK_ERR]))
      begin
         locked_region_error_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         bad_command_error_bit <= 1'b0;
      end
      else if (bad_command_error_in)
      begin
         bad_command_error_bit <= 1'b1;
      end
      else if (w1c(wr_stb, hit_status, pwdata_in[BIT_BAD_CMD]))
      begin
         bad_command_error_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         error_flag <= 1'b0;
      end
      else
      begin
         error_flag <= flash_error_in | locked_region_error_in
            | bad_command_error_in
            | (error_flag & ~w1c(wr_stb, hit_flag, pwdata_in[BIT_ERROR]));
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ready_flag <= 1'b0;
      end
      else
      begin
         ready_flag <= ~busy_in;
      end
   end

   // ***************
   // command address
   // ***************
   // a buffer load and a bus write in one cycle: the load wins, since
   // it names the page the pending write will really touch
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         command_address <= CMD_ADDR_RST;
      end
      else if (pb_load_in)
      begin
         command_address <= pb_addr_in;
      end
      else if (wr_stb && hit_addr)
      begin
         command_address <= pwdata_in[CMD_ADDR_W-1:0];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         flash_addr_out    <= 16'h0000;
         flash_cmd_stb_out <= 1'b0;
      end
      else
      begin
         flash_cmd_stb_out <= cmd_exec_in;
         if (cmd_exec_in)
         begin
            flash_addr_out <= command_address[HW_ADDR_W-1:0];
         end
      end
   end

   // ***************
   // region locks
   // ***************
   // no bus write path exists into the lock bank at all
   nsal_lock_bank #(.REGIONS_P(REGIONS_P)) u_lock
   (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .erase_in   (lock_erase_in),
      .cmd_stb_in (cmd_exec_in),
      .cmd_in     (cmd_in),
      .region_in  (command_address[3:0]),
      .lock_out   (region_lock_state)
   );

   // ***************
   // read data
   // ***************
   always_comb
   begin
      next_prdata = RDATA_ZERO;
      if (hit_status)
      begin
         next_prdata[BIT_POWER_RED] = power_reduction_flag;
         next_prdata[BIT_LOAD]      = page_buffer_loaded;
         next_prdata[BIT_BAD_CMD]   = bad_command_error_bit;
         next_prdata[BIT_LOCK_ERR]  = locked_region_error_bit;
         next_prdata[BIT_FLASH_ERR] = flash_error_bit;
      end
      else if (hit_addr)
      begin
         next_prdata[CMD_ADDR_W-1:0] = command_address;
      end
      else if (hit_flag)
      begin
         next_prdata[BIT_READY] = ready_flag;
         next_prdata[BIT_ERROR] = error_flag;
      end
      else if (hit_lock)
      begin
         next_prdata[REGIONS_P-1:0] = region_lock_state;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         prdata_out  <= RDATA_ZERO;
         pslverr_out <= 1'b0;
      end
      else
      begin
         if (rd_stb)
         begin
            prdata_out <= next_prdata;
         end
         pslverr_out <= psel_in & penable_in & ~pready_i
            & ~(hit_status | hit_addr | hit_flag | hit_lock);
      end
   end
endmodule // nsal_top
`default_nettype wire

// ==== include/nsal_pkg.sv ====
// package for the flash status, address and lock block
// assumes a 32-bit apb bus and one 50 mhz clock
package nsal_pkg;
   // ***************
   // register map
   // ***************
   localparam logic [7:0]  ADDR_STATUS   = 8'h18;
   localparam logic [7:0]  ADDR_CMD_ADDR = 8'h1C;
   localparam logic [7:0]  ADDR_LOCK     = 8'h20;
   localparam logic [7:0]  ADDR_INTFLAG  = 8'h14;
   localparam int          CMD_ADDR_W    = 22;
   localparam int          HW_ADDR_W     = 16;
   localparam int          LOCK_W        = 16;
   localparam int          REGIONS       = 16;
   // ***************
   // field positions and resets
   // ***************
   localparam int          BIT_POWER_RED = 0;
   localparam int          BIT_LOAD      = 1;
   localparam int          BIT_BAD_CMD   = 2;
   localparam int          BIT_LOCK_ERR  = 3;
   localparam int          BIT_FLASH_ERR = 4;
   localparam int          BIT_READY     = 0;
   localparam int          BIT_ERROR     = 1;
   localparam logic [21:0] CMD_ADDR_RST  = 22'h000000;
   localparam logic [15:0] LOCK_ERASED   = 16'hFFFF;
   localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
   // ***************
   // commands seen by the status logic
   // ***************
   typedef enum logic [2:0]
   {
      NSAL_CMD_NONE,
      NSAL_CMD_WRITE_PAGE,
      NSAL_CMD_PB_CLEAR,
      NSAL_CMD_SET_PWR_RED,
      NSAL_CMD_CLR_PWR_RED,
      NSAL_CMD_LOCK,
      NSAL_CMD_UNLOCK
   } nsal_cmd_type;
endpackage

// ==== verif/nsal_flash_model.sv ====
// model of the flash array and command engine facing the block
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
`default_nettype none
module nsal_flash_model
   import nsal_pkg::*;
#(
   parameter int BUSY_P = 20
)
(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   output logic [7:0]            ev_out,
   output logic [21:0]           addr_out,
   output logic                  exec_out,
   output nsal_pkg::nsal_cmd_type cmd_out,
   output logic                  busy_out
);
   int cnt;
   initial
   begin
      ev_out = 8'h00;
      addr_out = 22'h000000;
      exec_out = 1'b0;
      cmd_out = NSAL_CMD_NONE;
   end
   // a page write keeps the array busy for a while
   always_ff @(posedge clk_in)
      if (sys_rst_in)
         cnt <= 0;
      else if (exec_out && cmd_out == NSAL_CMD_WRITE_PAGE)
         cnt <= BUSY_P;
      else if (cnt != 0)
         cnt <= cnt - 1;
   assign busy_out = (cnt != 0);
   // released lines show the inverse, never a stale value
   task pulse(input int i, input logic [21:0] a);
      @(posedge clk_in);
      ev_out[i] <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      ev_out[i] <= 1'b0;
      addr_out <= ~a;
   endtask
   task cmd(input nsal_cmd_type c);
      @(posedge clk_in);
      exec_out <= 1'b1;
      cmd_out <= c;
      @(posedge clk_in);
      exec_out <= 1'b0;
      cmd_out <= nsal_cmd_type'(~c);
   endtask
endmodule // nsal_flash_model
`default_nettype wire

// ==== verif/nsal_monitor.sv ====
// checker for the flash status, address and lock block
// assumes it is bound to nsal_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module nsal_monitor
   import nsal_pkg::*;
#(
   parameter int REGIONS_P = 16
)
(
   input wire logic                   clk_in,
   input wire logic                   sys_rst_in,
   input wire logic                   pwrite_in,
   input wire logic [7:0]             paddr_in,
   input wire logic [31:0]            prdata_out,
   input wire logic                   pready_out,
   input wire logic                   pb_load_in,
   input wire logic [21:0]            pb_addr_in,
   input wire logic                   cmd_exec_in,
   input wire nsal_pkg::nsal_cmd_type cmd_in,
   input wire logic                   flash_access_in,
   input wire logic                   sleep_enter_in,
   input wire logic                   sleep_exit_in,
   input wire logic                   sleep_power_reduction_select_in,
   input wire logic                   busy_in,
   input wire logic                   flash_error_in,
   input wire logic                   locked_region_error_in,
   input wire logic                   bad_command_error_in,
   input wire logic [15:0]            flash_addr_out,
   input wire logic                   flash_cmd_stb_out,
   input wire logic                   power_reduction_out
);
   // ********************
   // helper terms
   // ********************
   wire logic sel = sleep_power_reduction_select_in;
   wire logic ex = cmd_exec_in;
   wire logic enter = (ex && cmd_in == NSAL_CMD_SET_PWR_RED)
                      || (sleep_enter_in && sel);
   wire logic leave = flash_access_in
                      || (ex && cmd_in == NSAL_CMD_CLR_PWR_RED)
                      || (sleep_exit_in && sel);
   wire logic rd = pready_out && !pwrite_in;
   wire logic rd_stat = rd && paddr_in == ADDR_STATUS;
   wire logic rd_int = rd && paddr_in == ADDR_INTFLAG;
   wire logic rd_lock = rd && paddr_in == ADDR_LOCK;
   wire logic wr_addr = pready_out && pwrite_in && paddr_in == ADDR_CMD_ADDR;
   wire logic err = flash_error_in || locked_region_error_in
                    || bad_command_error_in;
   wire logic [15:0] ld_lo = pb_addr_in[15:0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ********************
   // assertions
   // ********************
   chk_cmd_strobe: assert property (flash_cmd_stb_out == $past(ex))
      else $error("execute strobe out of step");
   chk_exec_addr: assert property (pb_load_in
      ##1 (!pb_load_in && !ex && !wr_addr)
      ##1 (ex && !pb_load_in) |=> flash_addr_out == $past(ld_lo, 3))
      else $error("flash address not the loaded address");
   chk_pr_enter: assert property (enter && !leave |-> ##2 power_reduction_out)
      else $error("power reduction not entered");
   chk_pr_leave: assert property (leave |-> ##2 !power_reduction_out)
      else $error("power reduction not left");
   chk_pr_read: assert property ((!enter && !leave)[*2] ##1 rd_stat
      |-> prdata_out[BIT_POWER_RED] == power_reduction_out)
      else $error("power reduction bit reads wrong");
   chk_load_read: assert property (pb_load_in ##1 (!pready_out && !ex)[*3]
      ##1 rd_stat |-> prdata_out[BIT_LOAD])
      else $error("loaded flag not set");
   chk_error_flag: assert property (err ##1 (!pready_out)[*3] ##1 rd_int
      |-> prdata_out[BIT_ERROR])
      else $error("error flag not set");
   chk_ready_flag: assert property (rd_int
      && $past(busy_in) == $past(busy_in, 2)
      |-> prdata_out[BIT_READY] == !$past(busy_in))
      else $error("ready flag wrong");
   chk_lock_width: assert property (rd_lock |-> prdata_out[31:16] == 16'h0000)
      else $error("lock register wider than its bits");
   cov_enter: cover property (enter ##2 power_reduction_out);
   cov_load: cover property (rd_stat && prdata_out[BIT_LOAD]);
   cov_exec: cover property (flash_cmd_stb_out);
endmodule // nsal_monitor
bind nsal_top nsal_monitor #(.REGIONS_P(REGIONS_P)) i_nsal_monitor (.clk_in,
   .sys_rst_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pb_load_in,
   .pb_addr_in, .cmd_exec_in, .cmd_in, .flash_access_in, .sleep_enter_in,
   .sleep_exit_in, .sleep_power_reduction_select_in, .busy_in,
   .flash_error_in, .locked_region_error_in, .bad_command_error_in,
   .flash_addr_out, .flash_cmd_stb_out, .power_reduction_out);
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: apb register tests with the flash model on the far side
// assumes nsal_top, the package and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
   import nsal_pkg::*;
   logic               clk_in, sys_rst_in, psel, penable, pwrite, sel, err;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, r;
   wire logic [31:0]   prdata;
   wire logic          pready, pslverr, stb, pr_out, exec, busy;
   wire logic [15:0]   faddr;
   wire logic [7:0]    ev;
   wire logic [21:0]   ld_addr;
   wire nsal_cmd_type  cmd;
   int                 failures, checks_done;
   nsal_top i_nsal_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .pb_load_in(ev[0]),
      .pb_addr_in(ld_addr), .cmd_exec_in(exec), .cmd_in(cmd),
      .flash_access_in(ev[1]), .sleep_enter_in(ev[2]), .sleep_exit_in(ev[3]),
      .sleep_power_reduction_select_in(sel), .lock_erase_in(ev[4]),
      .busy_in(busy), .flash_error_in(ev[5]), .locked_region_error_in(ev[6]),
      .bad_command_error_in(ev[7]), .flash_addr_out(faddr),
      .flash_cmd_stb_out(stb), .power_reduction_out(pr_out));
   nsal_flash_model i_nsal_flash_model (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .ev_out(ev), .addr_out(ld_addr),
      .exec_out(exec), .cmd_out(cmd), .busy_out(busy));
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         failures++;
         $display("wrong value at %0t: no pready from the slave", $time);
         final_report();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(r, e);
   endtask
   task pr_check(input logic e);
      repeat (2) @(negedge clk_in);
      chk({31'h0, pr_out}, {31'h0, e});
      rd(ADDR_STATUS, {31'h0, e});
   endtask
   initial
   begin
      sys_rst_in = 1'b1;
      {psel, penable, pwrite, sel} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      failures = 0;
      checks_done = 0;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rd(ADDR_LOCK, 32'h0000FFFF);
      rd(ADDR_STATUS, 32'h00000000);
      rd(ADDR_INTFLAG, 32'h00000001);
      apb(1'b1, ADDR_LOCK, 32'h00000000);
      rd(ADDR_LOCK, 32'h0000FFFF);
      apb(1'b1, ADDR_CMD_ADDR, 32'hFFFFFFFF);
      rd(ADDR_CMD_ADDR, 32'h003FFFFF);
      i_nsal_flash_model.pulse(0, 22'h2A5A5);
      rd(ADDR_STATUS, 32'h00000002);
      rd(ADDR_CMD_ADDR, 32'h0002A5A5);
      apb(1'b1, ADDR_STATUS, 32'h00000000);
      rd(ADDR_STATUS, 32'h00000002);
      apb(1'b1, ADDR_STATUS, 32'h00000002);
      rd(ADDR_STATUS, 32'h00000000);
      i_nsal_flash_model.pulse(0, 22'h00010);
      i_nsal_flash_model.cmd(NSAL_CMD_PB_CLEAR);
      rd(ADDR_STATUS, 32'h00000000);
      i_nsal_flash_model.pulse(0, 22'h2A5A5);
      i_nsal_flash_model.cmd(NSAL_CMD_WRITE_PAGE);
      @(negedge clk_in);
      chk({31'h0, stb}, 32'h00000001);
      chk({16'h0, faddr}, 32'h0000A5A5);
      rd(ADDR_STATUS, 32'h00000000);
      rd(ADDR_INTFLAG, 32'h00000000);
      repeat (24) @(posedge clk_in);
      rd(ADDR_INTFLAG, 32'h00000001);
      // boundary region, then erase restores all
      apb(1'b1, ADDR_CMD_ADDR, 32'h0000000F);
      i_nsal_flash_model.cmd(NSAL_CMD_LOCK);
      rd(ADDR_LOCK, 32'h00007FFF);
      i_nsal_flash_model.cmd(NSAL_CMD_UNLOCK);
      rd(ADDR_LOCK, 32'h0000FFFF);
      i_nsal_flash_model.cmd(NSAL_CMD_LOCK);
      i_nsal_flash_model.pulse(4, 22'h00000);
      rd(ADDR_LOCK, 32'h0000FFFF);
      i_nsal_flash_model.cmd(NSAL_CMD_SET_PWR_RED);
      pr_check(1'b1);
      i_nsal_flash_model.pulse(1, 22'h00000);
      pr_check(1'b0);
      sel <= 1'b1;
      i_nsal_flash_model.pulse(2, 22'h00000);
      pr_check(1'b1);
      i_nsal_flash_model.pulse(3, 22'h00000);
      pr_check(1'b0);
      i_nsal_flash_model.cmd(NSAL_CMD_SET_PWR_RED);
      i_nsal_flash_model.cmd(NSAL_CMD_CLR_PWR_RED);
      pr_check(1'b0);
      sel <= 1'b0;
      i_nsal_flash_model.pulse(2, 22'h00000);
      pr_check(1'b0);
      i_nsal_flash_model.cmd(NSAL_CMD_SET_PWR_RED);
      i_nsal_flash_model.pulse(3, 22'h00000);
      pr_check(1'b1);
      apb(1'b1, ADDR_STATUS, 32'h00000001);
      rd(ADDR_STATUS, 32'h00000001);
      i_nsal_flash_model.pulse(1, 22'h00000);
      for (int i = 0; i < 3; i++)
      begin
         i_nsal_flash_model.pulse(7 - i, 22'h00000);
         rd(ADDR_INTFLAG, 32'h00000003);
         rd(ADDR_STATUS, 32'h00000004 << i);
         apb(1'b1, ADDR_STATUS, 32'h00000004 << i);
         apb(1'b1, ADDR_INTFLAG, 32'h00000002);
         rd(ADDR_INTFLAG, 32'h00000001);
      end
      rd(8'h40, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
      final_report();
   end
endmodule // tb
`default_nettype wire
